// ===== pipe_model.sv
// pipeline model issuing fetch and load/store translations
`timescale 1ns/100ps
`default_nettype none
module pipe_model (
	input  wire logic   clk_sys,
	input  wire logic   fetch_done,
	input  wire logic   data_done,
	output logic        fetch_req,
	output logic [31:0] fetch_vaddr,
	output logic        data_req,
	output logic        data_write,
	output logic [31:0] data_vaddr
);
	// idle at time zero
	initial begin
		fetch_req = 1'b0;
		data_req = 1'b0;
		data_write = 1'b0;
		fetch_vaddr = 32'h0;
		data_vaddr = 32'h0;
	end
	// hold one request until its done, then scramble the address lines
	task automatic access(input logic f, input logic w, input logic [31:0] a);
		@(posedge clk_sys);
		fetch_req <= f;
		data_req <= !f;
		data_write <= w;
		fetch_vaddr <= a;
		data_vaddr <= a;
		do @(posedge clk_sys); while (!(fetch_done || data_done));
		fetch_req <= 1'b0;
		data_req <= 1'b0;
		fetch_vaddr <= ~a;
		data_vaddr <= ~a;
	endtask
endmodule // pipe_model
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the translation unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clk_sys, reset_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, fetch_vaddr, data_vaddr;
	logic [31:0] fetch_paddr, data_paddr;
	logic [1:0]  htrans, fetch_cache_mode, data_cache_mode;
	logic [2:0]  hsize, fetch_exc, data_exc;
	logic        fetch_req, fetch_done, data_req, data_write, data_done;
	logic        shutdown_flag, machine_check;
	int          miscompares, checked, seed, mc_seen;
	logic [37:0] expq[$]; // full flag, paddr, cache mode, fault
	localparam logic [37:0] miss_e = {1'b1, 32'h0, 2'h2, 3'h1};
	assign hready = hreadyout;
	tlb_xlate DUT (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .fetch_req(fetch_req),
		.fetch_vaddr(fetch_vaddr), .fetch_done(fetch_done),
		.fetch_paddr(fetch_paddr), .fetch_cache_mode(fetch_cache_mode),
		.fetch_exc(fetch_exc), .data_req(data_req), .data_write(data_write),
		.data_vaddr(data_vaddr), .data_done(data_done),
		.data_paddr(data_paddr), .data_cache_mode(data_cache_mode),
		.data_exc(data_exc), .shutdown_flag(shutdown_flag),
		.machine_check(machine_check));
	pipe_model pm (.clk_sys(clk_sys), .fetch_done(fetch_done),
		.data_done(data_done), .fetch_req(fetch_req),
		.fetch_vaddr(fetch_vaddr), .data_req(data_req),
		.data_write(data_write), .data_vaddr(data_vaddr));
	// core clock, 10 ns
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// compare one value
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// one bus transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk("register", e, r);
	endtask
	// load tag and both attributes, then write one entry by index
	task automatic entry(input logic [31:0] t, input logic [31:0] ev, input logic [31:0] od, input logic [31:0] ix);
		wr(8'h04, t);
		wr(8'h08, ev);
		wr(8'h0c, od);
		wr(8'h10, ix);
		wr(8'h20, 32'h1);
	endtask
	// note the expected result, then issue the translation
	task automatic go(input logic f, input logic w, input logic [31:0] a, input logic [37:0] e);
		expq.push_back(e);
		pm.access(f, w, a);
		@(posedge clk_sys);
	endtask
	// result watcher: takes the oldest note on each done
	always @(posedge clk_sys) begin : mon
		logic [37:0] e;
		logic [36:0] g;
		if (fetch_done === 1'b1 || data_done === 1'b1) begin
			e = (expq.size() > 0) ? expq.pop_front() : '1;
			g = fetch_done ? {fetch_paddr, fetch_cache_mode, fetch_exc} : {data_paddr, data_cache_mode, data_exc};
			chk("fault", {29'h0, e[2:0]}, {29'h0, g[2:0]});
			if (e[37]) begin
				chk("paddr", e[36:5], g[36:5]);
				chk("cache mode", {30'h0, e[4:3]}, {30'h0, g[4:3]});
			end
		end
		if (machine_check === 1'b1) mc_seen++;
	end
	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end
	initial begin : main
		logic [11:0] off;
		logic [15:0] cmt;
		cmt = 16'hbfe4; // decoded mode per cache code
		{reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		{miscompares, checked, mc_seen} = '0;
		seed = 74256;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		go(1'b0, 1'b0, 32'h00010000, miss_e);
		wr(8'h00, 32'h0);
		rd(8'h2c, 32'h0);
		rd(8'h28, 32'h1);
		for (int i = 0; i < 8; i++) begin
			off = 12'($random(seed));
			entry(32'h00010005, 32'h0002af06 | (32'(i) << 3), 32'h00037bc0, 32'h1);
			go(1'b0, 1'b0, {20'h00010, off}, {1'b1, 20'h00abc, off, cmt[2*i +: 2], 3'h0});
		end
		$display("test cache codes done");
		go(1'b1, 1'b0, 32'h00010004, {1'b1, 20'h00abc, 12'h004, 5'h10});
		go(1'b0, 1'b1, 32'h00010008, {1'b1, 20'h00abc, 12'h008, 5'h10});
		entry(32'h00010005, 32'h0002af3a, 32'h00037bc0, 32'h1);
		go(1'b0, 1'b1, 32'h00010008, {35'h0, 3'h3});
		go(1'b0, 1'b0, 32'h00011000, {35'h0, 3'h2});
		$display("test page faults done");
		wr(8'h1c, 32'h2);
		entry(32'h00010005, 32'hc002af3e, 32'h00037bc0, 32'h1);
		go(1'b0, 1'b0, 32'h00010000, {35'h0, 3'h4});
		go(1'b1, 1'b0, 32'h00010000, {35'h0, 3'h5});
		wr(8'h1c, 32'h0);
		go(1'b0, 1'b0, 32'h00010010, {1'b1, 20'h00abc, 12'h010, 5'h10});
		$display("test inhibit done");
		for (int g = 1; g >= 0; g--) begin
			entry(32'h00010005, 32'h00022f07, 32'h00037bc0 | 32'(g), 32'h1);
			wr(8'h04, 32'h00010006);
			go(1'b0, 1'b0, 32'h00010000, g ? {1'b1, 20'h008bc, 12'h0, 5'h0} : miss_e);
		end
		wr(8'h04, 32'h00010005);
		go(1'b0, 1'b0, 32'h00010000, {1'b1, 20'h008bc, 12'h0, 5'h0});
		$display("test identifier done");
		entry(32'h00010005, 32'h00001006, 32'h00037bc0, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk("machine check", 32'h1, 32'(mc_seen));
		rd(8'h24, 32'h1);
		wr(8'h24, 32'h1);
		rd(8'h24, 32'h0);
		go(1'b0, 1'b0, 32'h00010000, {1'b1, 20'h008bc, 12'h0, 5'h0});
		wr(8'h04, 32'h00020005);
		wr(8'h20, 32'h2);
		go(1'b0, 1'b0, 32'h00020000, {1'b1, 20'h00040, 12'h0, 5'h0});
		wr(8'h1c, 32'h1);
		entry(32'h00010005, 32'h0002af06, 32'h00037bc0, 32'h1);
		go(1'b0, 1'b0, 32'h00010004, {1'b1, 32'h002af004, 5'h0});
		$display("test duplicate and random done");
		chk("pending", 32'h0, 32'(expq.size()));
		print_verdict();
	end
endmodule // testbench
bind tlb_xlate tlb_xlate_asserts chk_i (.clk_sys(clk_sys),
	.reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.fetch_req(fetch_req), .fetch_done(fetch_done),
	.fetch_exc(fetch_exc), .data_req(data_req), .data_done(data_done),
	.data_paddr(data_paddr), .data_cache_mode(data_cache_mode),
	.data_exc(data_exc), .shutdown_flag(shutdown_flag),
	.machine_check(machine_check));
`default_nettype wire

// ===== tlb_xlate.sv
// joint and micro translation tables with an ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "tlb_xlate_regs.svh"
module tlb_xlate #(
	parameter int   JOINT_ENTRIES      = 32,
	parameter logic SMALL_PAGE_PRESENT = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_vaddr,
	output logic             fetch_done,
	output logic [31:0]      fetch_paddr,
	output logic [1:0]       fetch_cache_mode,
	output logic [2:0]       fetch_exc,
	input  wire logic        data_req,
	input  wire logic        data_write,
	input  wire logic [31:0] data_vaddr,
	output logic             data_done,
	output logic [31:0]      data_paddr,
	output logic [1:0]       data_cache_mode,
	output logic [2:0]       data_exc,
	output logic             shutdown_flag,
	output logic             machine_check
);
	localparam int IDX_W = $clog2(JOINT_ENTRIES);
	// highest entry index, also the index mask
	localparam logic [4:0] MAX_IDX = 5'(JOINT_ENTRIES - 1);

	// only the two build sizes are served
	if (!(JOINT_ENTRIES == 16 || JOINT_ENTRIES == 32)) begin : g_bad_size
		$error("joint table size must be 16 or 32");
	end

	// whole state of the unit
	typedef struct packed {
		tlb_xlate_pkg::joint_entry_t [JOINT_ENTRIES-1:0] jt;
		tlb_xlate_pkg::micro_entry_t [3:0]              fm;
		tlb_xlate_pkg::micro_entry_t [3:0]              dm;
		logic [1:0]                  fm_ptr;  // fetch victim
		logic [1:0]                  dm_ptr;  // data victim
		logic [17:0]                 psm;     // page size mask
		logic [20:0]                 vpair;   // pair number and extension
		logic [7:0]                  space_identifier;    // current space identifier
		tlb_xlate_pkg::page_attr_t   even_a;
		tlb_xlate_pkg::page_attr_t   odd_a;
		logic                        even_g;
		logic                        odd_g;
		logic [4:0]                  index;
		logic [4:0]                  wired;
		logic [4:0]                  random;
		logic [9:0]                  lfsr;
		logic                        spe;     // small pages enabled
		logic                        iec;     // inhibit faults enabled
		logic                        shutdown;
		logic                        mcheck;
		tlb_xlate_pkg::fetch_state_t fst;
		logic                        f_done;
		logic [31:0]                 f_paddr;
		tlb_xlate_pkg::cache_mode_t  f_cm;
		tlb_xlate_pkg::xlate_exc_t   f_exc;
		logic                        d_done;
		logic [31:0]                 d_paddr;
		tlb_xlate_pkg::cache_mode_t  d_cm;
		tlb_xlate_pkg::xlate_exc_t   d_exc;
		logic                        aph_v;   // bus data phase pending
		logic                        aph_w;
		logic [7:0]                  aph_a;
		logic                        rd_wait; // read wait state
		logic [31:0]                 rdata;
	} state_t;

	state_t state_q;  // registered state
	state_t state_d;  // next state

	// three-bit cache code to behaviour
	function automatic tlb_xlate_pkg::cache_mode_t cm_decode(
		input logic [2:0] c);
		unique case (c)
			3'h0:    cm_decode = tlb_xlate_pkg::CM_WT_NOALLOC;
			3'h1:    cm_decode = tlb_xlate_pkg::CM_WT_ALLOC;
			3'h2:    cm_decode = tlb_xlate_pkg::CM_UNCACHED;
			3'h7:    cm_decode = tlb_xlate_pkg::CM_UNCACHED;
			default: cm_decode = tlb_xlate_pkg::CM_WB_ALLOC;
		endcase
	endfunction

	// pair match with a combined size mask; unwritten entries never match
	function automatic logic pair_match(
		input tlb_xlate_pkg::joint_entry_t e,
		input logic [20:0] tag,
		input logic [17:0] mask,
		input logic [7:0]  space_identifier,
		input logic        g,
		input logic        spe);
		logic [20:0] m21;
		m21 = {3'h0, e.mask | mask};
		// without small pages the extension bits never take part
		if (!spe) begin
			m21[1:0] = 2'h3;
		end
		pair_match = e.init
			&& (((e.tag ^ tag) & ~m21) == 21'h0)
			&& (e.g || g || (e.space_identifier == space_identifier));
	endfunction

	// full joint lookup, result shaped as a micro entry
	function automatic tlb_xlate_pkg::micro_entry_t joint_find(
		input tlb_xlate_pkg::joint_entry_t [JOINT_ENTRIES-1:0] jt,
		input logic [31:0] va,
		input logic [7:0]  space_identifier,
		input logic        spe);
		tlb_xlate_pkg::micro_entry_t r;
		tlb_xlate_pkg::page_attr_t   pa;
		logic [17:0]                 msk;
		logic [21:0]                 pp;
		int                          sel;
		r = '0;
		pa = '0;
		msk = '0;
		pp = '0;
		sel = 10;
		for (int i = 0; i < JOINT_ENTRIES; i++) begin
			if (pair_match(jt[i], va[31:11], 18'h0, space_identifier, 1'b0, spe)) begin
				msk = jt[i].mask;
				if (!spe) begin
					msk[1:0] = 2'h3;
				end
				// highest bit left out of the compare picks the half
				sel = 10;
				for (int k = 0; k < 18; k++) begin
					if (msk[k]) begin
						sel = 11 + k;
					end
				end
				pa = va[sel] ? jt[i].odd : jt[i].even;
				// frame placed at 1 KB or 4 KB granularity
				pp = spe ? {2'h0, pa.pfn} : {pa.pfn, 2'h0};
				// offset bits of large pages pass untranslated
				for (int k = 0; k < 22; k++) begin
					if (10 + k < sel) begin
						pp[k] = va[10 + k];
					end
				end
				r.v = 1'b1;
				r.tiny = spe;
				r.vtag = va[31:10];
				r.space_identifier = space_identifier;
				r.g = jt[i].g;
				r.ppage = pp;
				r.cattr = pa.cattr;
				r.rp = pa.rp;
				r.xp = pa.xp;
				r.we = pa.we;
				r.pv = pa.v;
			end
		end
		joint_find = r;
	endfunction

	// micro lookup over four subpage entries
	function automatic tlb_xlate_pkg::micro_entry_t micro_find(
		input tlb_xlate_pkg::micro_entry_t [3:0] m,
		input logic [31:0] va,
		input logic [7:0]  space_identifier);
		tlb_xlate_pkg::micro_entry_t r;
		logic                        tag_ok;
		r = '0;
		tag_ok = 1'b0;
		for (int i = 0; i < 4; i++) begin
			// 4 KB subpages ignore the two lowest tag bits
			tag_ok = m[i].tiny ? (m[i].vtag == va[31:10])
				: (m[i].vtag[21:2] == va[31:12]);
			if (m[i].v && tag_ok && (m[i].g || m[i].space_identifier == space_identifier)) begin
				r = m[i];
			end
		end
		micro_find = r;
	endfunction

	// physical address from a micro hit
	function automatic logic [31:0] form_pa(
		input tlb_xlate_pkg::micro_entry_t m,
		input logic [31:0] va);
		form_pa = m.tiny ? {m.ppage, va[9:0]}
			: {m.ppage[21:2], va[11:0]};
	endfunction

	// fault of a finished access, in priority order
	function automatic tlb_xlate_pkg::xlate_exc_t fault(
		input tlb_xlate_pkg::micro_entry_t m,
		input logic fetch,
		input logic store,
		input logic iec);
		if (fetch && iec && m.xp) begin
			fault = tlb_xlate_pkg::EXC_EXEC_INHIBIT;
		end else if (!fetch && !store && iec && m.rp) begin
			fault = tlb_xlate_pkg::EXC_READ_INHIBIT;
		end else if (!m.pv) begin
			fault = tlb_xlate_pkg::EXC_INVALID;
		end else if (!fetch && store && !m.we) begin
			fault = tlb_xlate_pkg::EXC_MODIFIED;
		end else begin
			fault = tlb_xlate_pkg::EXC_NONE;
		end
	endfunction

	// next state of the whole unit
	always_comb begin
		tlb_xlate_pkg::micro_entry_t fh;
		tlb_xlate_pkg::micro_entry_t dh;
		tlb_xlate_pkg::micro_entry_t jd;
		tlb_xlate_pkg::micro_entry_t jf;
		tlb_xlate_pkg::joint_entry_t ne;
		logic       wr_dp;
		logic       op_idx;
		logic       op_rnd;
		logic       flush;
		logic       busy;
		logic       dup;
		logic       d_joint;
		logic [4:0] tgt;
		fh = '0;
		dh = '0;
		jd = '0;
		jf = '0;
		ne = '0;
		op_idx = 1'b0;
		op_rnd = 1'b0;
		flush = 1'b0;
		dup = 1'b0;
		d_joint = 1'b0;
		tgt = '0;
		wr_dp = 1'b0;
		busy = 1'b0;
		state_d = state_q;
		state_d.f_done = 1'b0;
		state_d.d_done = 1'b0;
		state_d.mcheck = 1'b0;
		// free-running shift register, taps ten and seven
		state_d.lfsr = {state_q.lfsr[8:0],
			state_q.lfsr[9] ^ state_q.lfsr[6]};
		// decrement skipped when the low shift bits are all zero
		if (state_q.lfsr[2:0] != 3'h0) begin
			if (state_q.random == state_q.wired
				|| state_q.random == 5'h00) begin
				state_d.random = MAX_IDX;
			end else begin
				state_d.random = state_q.random - 5'h01;
			end
		end
		// read wait state: capture data one cycle after the address
		if (state_q.rd_wait) begin
			state_d.rd_wait = 1'b0;
			unique case (state_q.aph_a)
				`REG_PAGE_SIZE_MASK: state_d.rdata =
					{3'h0, state_q.psm, 11'h000};
				`REG_VIRTUAL_TAG: state_d.rdata =
					{state_q.vpair, 3'h0, state_q.space_identifier};
				`REG_EVEN_ATTR: state_d.rdata = {state_q.even_a.rp,
					state_q.even_a.xp, 4'h0, state_q.even_a.pfn,
					state_q.even_a.cattr, state_q.even_a.we,
					state_q.even_a.v, state_q.even_g};
				`REG_ODD_ATTR: state_d.rdata = {state_q.odd_a.rp,
					state_q.odd_a.xp, 4'h0, state_q.odd_a.pfn,
					state_q.odd_a.cattr, state_q.odd_a.we,
					state_q.odd_a.v, state_q.odd_g};
				`REG_INDEX:  state_d.rdata = {27'h0, state_q.index};
				`REG_WIRED:  state_d.rdata = {27'h0, state_q.wired};
				`REG_RANDOM: state_d.rdata = {27'h0, state_q.random};
				`REG_GRANULARITY: state_d.rdata =
					{30'h0, state_q.iec, state_q.spe};
				`REG_STATUS: state_d.rdata = {31'h0, state_q.shutdown};
				`REG_FEATURE_CONFIG: state_d.rdata =
					{31'h0, SMALL_PAGE_PRESENT};
				// command and unmapped offsets read zero
				default: state_d.rdata = 32'h0;
			endcase
		end
		// write data phase, always zero wait
		wr_dp = state_q.aph_v && state_q.aph_w;
		if (wr_dp) begin
			unique case (state_q.aph_a)
				`REG_PAGE_SIZE_MASK: state_d.psm =
					hwdata[`MASK_MSB:`MASK_LSB];
				`REG_VIRTUAL_TAG: begin
					state_d.vpair = hwdata[31:`VPAIR_LSB];
					state_d.space_identifier = hwdata[`SPACE_IDENTIFIER_MSB:0];
					flush = hwdata[`SPACE_IDENTIFIER_MSB:0] != state_q.space_identifier;
				end
				`REG_EVEN_ATTR: begin
					state_d.even_a = {hwdata[`ATTR_RP_BIT],
						hwdata[`ATTR_XP_BIT],
						hwdata[`ATTR_PFN_MSB:`ATTR_PFN_LSB],
						hwdata[`ATTR_C_MSB:`ATTR_C_LSB],
						hwdata[`ATTR_WE_BIT], hwdata[`ATTR_V_BIT]};
					state_d.even_g = hwdata[`ATTR_G_BIT];
				end
				`REG_ODD_ATTR: begin
					state_d.odd_a = {hwdata[`ATTR_RP_BIT],
						hwdata[`ATTR_XP_BIT],
						hwdata[`ATTR_PFN_MSB:`ATTR_PFN_LSB],
						hwdata[`ATTR_C_MSB:`ATTR_C_LSB],
						hwdata[`ATTR_WE_BIT], hwdata[`ATTR_V_BIT]};
					state_d.odd_g = hwdata[`ATTR_G_BIT];
				end
				`REG_INDEX: state_d.index = hwdata[4:0] & MAX_IDX;
				`REG_WIRED: begin
					state_d.wired = hwdata[4:0] & MAX_IDX;
					state_d.random = MAX_IDX;
				end
				`REG_GRANULARITY: begin
					// small pages only where built in
					state_d.spe = hwdata[`GRAN_SPE_BIT]
						& SMALL_PAGE_PRESENT;
					state_d.iec = hwdata[`GRAN_IEC_BIT];
				end
				`REG_COMMAND: begin
					op_idx = hwdata[`CMD_INDEXED_BIT];
					op_rnd = hwdata[`CMD_RANDOM_BIT];
				end
				`REG_STATUS: begin
					// write one clears the shutdown flag
					if (hwdata[`STATUS_SHUTDOWN_BIT]) begin
						state_d.shutdown = 1'b0;
					end
				end
				// random, feature and unmapped offsets ignore writes
				default: ;
			endcase
		end
		// address phase taken while the bus is ready
		if (hready) begin
			state_d.aph_v = hsel && htrans[1];
			state_d.aph_w = hwrite;
			state_d.aph_a = {haddr[7:2], 2'h0};
			state_d.rd_wait = hsel && htrans[1] && !hwrite;
		end
		// entry write built from the staging registers
		if (op_idx || op_rnd) begin
			tgt = op_rnd ? state_q.random : state_q.index;
			ne.init = 1'b1;
			ne.mask = state_q.psm;
			ne.tag = state_q.vpair;
			ne.space_identifier = state_q.space_identifier;
			ne.g = state_q.even_g & state_q.odd_g;
			ne.even = state_q.even_a;
			ne.odd = state_q.odd_a;
			// compare against every other written pair
			for (int i = 0; i < JOINT_ENTRIES; i++) begin
				if (5'(i) != tgt && pair_match(state_q.jt[i], ne.tag,
					ne.mask, ne.space_identifier, ne.g, state_q.spe)) begin
					dup = 1'b1;
				end
			end
			if (dup) begin
				state_d.mcheck = 1'b1;
			end else begin
				state_d.jt[tgt[IDX_W-1:0]] = ne;
			end
			flush = 1'b1;
		end
		// set wins over a clear in the same cycle
		if (dup) begin
			state_d.shutdown = 1'b1;
		end
		// stale micro entries dropped, no lookups this cycle
		busy = flush;
		if (flush) begin
			for (int i = 0; i < 4; i++) begin
				state_d.fm[i].v = 1'b0;
				state_d.dm[i].v = 1'b0;
			end
		end
		// data side: micro and joint looked up together
		if (!busy && data_req && !state_q.d_done) begin
			dh = micro_find(state_q.dm, data_vaddr, state_q.space_identifier);
			jd = joint_find(state_q.jt, data_vaddr, state_q.space_identifier,
				state_q.spe);
			if (dh.v) begin
				state_d.d_done = 1'b1;
				state_d.d_paddr = form_pa(dh, data_vaddr);
				state_d.d_cm = cm_decode(dh.cattr);
				state_d.d_exc = fault(dh, 1'b0, data_write,
					state_q.iec);
			end else if (jd.v) begin
				// reload now, retried hit next cycle
				state_d.dm[state_q.dm_ptr] = jd;
				state_d.dm_ptr = state_q.dm_ptr + 2'h1;
				d_joint = 1'b1;
			end else begin
				state_d.d_done = 1'b1;
				state_d.d_paddr = 32'h0;
				state_d.d_cm = tlb_xlate_pkg::CM_UNCACHED;
				state_d.d_exc = tlb_xlate_pkg::EXC_MISS;
				d_joint = 1'b1;
			end
		end
		// fetch side: micro first, joint walk in a later cycle
		unique case (state_q.fst)
			tlb_xlate_pkg::F_IDLE: begin
				if (!busy && fetch_req && !state_q.f_done) begin
					fh = micro_find(state_q.fm, fetch_vaddr,
						state_q.space_identifier);
					if (fh.v) begin
						state_d.f_done = 1'b1;
						state_d.f_paddr = form_pa(fh, fetch_vaddr);
						state_d.f_cm = cm_decode(fh.cattr);
						state_d.f_exc = fault(fh, 1'b1, 1'b0,
							state_q.iec);
					end else begin
						state_d.fst = tlb_xlate_pkg::F_WALK;
					end
				end
			end
			tlb_xlate_pkg::F_WALK: begin
				// waits while the joint table serves data or a write
				if (!busy && !d_joint) begin
					jf = joint_find(state_q.jt, fetch_vaddr,
						state_q.space_identifier, state_q.spe);
					state_d.fst = tlb_xlate_pkg::F_IDLE;
					if (jf.v) begin
						state_d.fm[state_q.fm_ptr] = jf;
						state_d.fm_ptr = state_q.fm_ptr + 2'h1;
					end else begin
						state_d.f_done = 1'b1;
						state_d.f_paddr = 32'h0;
						state_d.f_cm = tlb_xlate_pkg::CM_UNCACHED;
						state_d.f_exc = tlb_xlate_pkg::EXC_MISS;
					end
				end
			end
		endcase
	end

	// state register; power-on reset clears every initialized flag
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= '0;
			state_q.lfsr <= `LFSR_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs
	assign hreadyout        = !state_q.rd_wait;
	assign hresp            = 1'b0;
	assign hrdata           = state_q.rdata;
	assign fetch_done       = state_q.f_done;
	assign fetch_paddr      = state_q.f_paddr;
	assign fetch_cache_mode = state_q.f_cm;
	assign fetch_exc        = state_q.f_exc;
	assign data_done        = state_q.d_done;
	assign data_paddr       = state_q.d_paddr;
	assign data_cache_mode  = state_q.d_cm;
	assign data_exc         = state_q.d_exc;
	assign shutdown_flag    = state_q.shutdown;
	assign machine_check    = state_q.mcheck;
endmodule // tlb_xlate
`default_nettype wire

// ===== tlb_xlate_asserts.sv
// port checks for the translation unit
`timescale 1ns/100ps
`default_nettype none
module tlb_xlate_asserts (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        fetch_req,
	input wire logic        fetch_done,
	input wire logic [2:0]  fetch_exc,
	input wire logic        data_req,
	input wire logic        data_done,
	input wire logic [31:0] data_paddr,
	input wire logic [1:0]  data_cache_mode,
	input wire logic [2:0]  data_exc,
	input wire logic        shutdown_flag,
	input wire logic        machine_check
);
	// all checks on the core clock, off in reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// a read data phase stalls exactly one cycle
	sequence rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	// transfer accepted at this edge
	wire logic taken = hready && hsel && htrans[1];
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	AST_RD_WAIT: assert property (taken && !hwrite |=> rd_wait)
		else $error("read data phase length wrong");
	AST_WR_NOWAIT: assert property (taken && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	AST_DATA_BOUND: assert property ($rose(data_req) |-> ##[1:8] data_done)
		else $error("data translation late");
	AST_FETCH_BOUND: assert property ($rose(fetch_req) |-> ##[1:8] fetch_done)
		else $error("fetch translation late");
	AST_DONE_CAUSE: assert property (data_done |-> $past(data_req) && !$past(data_done))
		else $error("data done without request");
	AST_MISS_RESULT: assert property (data_done && data_exc == 3'h1 |-> data_paddr == 32'h0 && data_cache_mode == 2'h2)
		else $error("miss result fields wrong");
	AST_FETCH_FAULT: assert property (fetch_done |-> fetch_exc != 3'h3 && fetch_exc != 3'h4)
		else $error("fetch given a data fault");
	AST_SHUTDOWN: assert property (machine_check |-> shutdown_flag)
		else $error("shutdown not set on abort");
	AST_MC_PULSE: assert property (machine_check |=> !machine_check)
		else $error("machine check longer than a cycle");
endmodule // tlb_xlate_asserts
`default_nettype wire

// ===== tlb_xlate_pkg.sv
// types shared by the translation unit
`default_nettype none
package tlb_xlate_pkg;
	// fault reported with a finished translation
	typedef enum logic [2:0] {
		EXC_NONE, EXC_MISS, EXC_INVALID, EXC_MODIFIED,
		EXC_READ_INHIBIT, EXC_EXEC_INHIBIT
	} xlate_exc_t;
	// decoded cache behaviour of a page
	typedef enum logic [1:0] {
		CM_WT_NOALLOC, CM_WT_ALLOC, CM_UNCACHED, CM_WB_ALLOC
	} cache_mode_t;
	// fetch walk sequencer
	typedef enum logic {F_IDLE, F_WALK} fetch_state_t;
	// attributes of one page of a pair
	typedef struct packed {
		logic        rp;
		logic        xp;
		logic [19:0] pfn;
		logic [2:0]  cattr;
		logic        we;
		logic        v;
	} page_attr_t;
	// one dual entry of the joint table
	typedef struct packed {
		logic        init;
		logic [17:0] mask;
		logic [20:0] tag;
		logic [7:0]  space_identifier;
		logic        g;
		page_attr_t  even;
		page_attr_t  odd;
	} joint_entry_t;
	// one micro entry, also the result of a joint lookup
	typedef struct packed {
		logic        v;
		logic        tiny;
		logic [21:0] vtag;
		logic [7:0]  space_identifier;
		logic        g;
		logic [21:0] ppage;
		logic [2:0]  cattr;
		logic        rp;
		logic        xp;
		logic        we;
		logic        pv;
	} micro_entry_t;
endpackage
`default_nettype wire

// ===== tlb_xlate_regs.svh
// register offsets, field positions and reset values of the translation unit
// Summary of operation
// - cache codes 4-6 act as 3, 7 as 2
// - read-protected page read gives read-inhibit fault
// - exec-protected page fetch gives execute-inhibit fault
// - store needs write enable, else modified fault
// - matched page with valid clear gives invalid fault
// - entry written from mask, tag and attribute registers
// - stored global is AND of both globals
// - current space identifier compared on every lookup
// - fetch micro table: four entries, small pages
// - fetch micro miss walks joint table in the next cycle not used by data or a write
// - data micro table: four entries, small pages
// - data lookup probes joint table in parallel
// - hit needs page match and global or identifier
// - no joint match raises a miss fault
// - physical address is frame plus untranslated offset
// - pair page sizes from 1 KB to 256 MB
// - random index decrements, wraps at wired floor
// - ten-bit shift register perturbs random decrement
// - duplicate pair on write aborts, sets shutdown
// - hidden initialized flag gates every match
// - joint table holds 16 or 32 pairs
// - highest masked-out bit picks even or odd
// - small granularity shifts frame, top bits zero
`ifndef TLB_XLATE_REGS_SVH
`define TLB_XLATE_REGS_SVH
`define REG_PAGE_SIZE_MASK  8'h00
`define REG_VIRTUAL_TAG     8'h04
`define REG_EVEN_ATTR       8'h08
`define REG_ODD_ATTR        8'h0c
`define REG_INDEX           8'h10
`define REG_WIRED           8'h14
`define REG_RANDOM          8'h18
`define REG_GRANULARITY     8'h1c
`define REG_COMMAND         8'h20
`define REG_STATUS          8'h24
`define REG_FEATURE_CONFIG  8'h28
`define MASK_LSB            11
`define MASK_MSB            28
`define VPAIR_LSB           11
`define SPACE_IDENTIFIER_MSB            7
`define ATTR_RP_BIT         31
`define ATTR_XP_BIT         30
`define ATTR_PFN_MSB        25
`define ATTR_PFN_LSB        6
`define ATTR_C_MSB          5
`define ATTR_C_LSB          3
`define ATTR_WE_BIT         2
`define ATTR_V_BIT          1
`define ATTR_G_BIT          0
`define GRAN_SPE_BIT        0
`define GRAN_IEC_BIT        1
`define CMD_INDEXED_BIT     0
`define CMD_RANDOM_BIT      1
`define STATUS_SHUTDOWN_BIT 0
`define LFSR_RESET          10'h001
`endif
